// ===== verilog/flash_access_pkg.sv
package flash_access_pkg;
  localparam int          ADDR_W          = 24;
  localparam int          DATA_W          = 32;
  localparam int          MOD_W           = 3;
  localparam int          NUM_MODULES     = 7;
  localparam int          WAIT_W          = 3;
  localparam int          EXT_W           = 2;
  localparam int          MOD_SHIFT       = 21;
  localparam int          PAGE_MSB        = 20;
  localparam int          PAGE_LSB        = 7;
  localparam int          PAR_LIMIT_ONE   = 7;
  localparam int          PAR_LIMIT_MANY  = 1;
  localparam logic [2:0]  FREE_MODULE     = 3'h6;
  localparam logic [2:0]  WAIT_RESET      = 3'h4;
  localparam logic [1:0]  EXT_RESET       = 2'h0;
  localparam logic [DATA_W-1:0] ERASED_WORD = 32'hFFFFFFFF;
  localparam int          CLK_MHZ         = 125;
  localparam int          TICK_DIV        = 25;
  localparam int          ERASE_MAX_US    = 8000;
  localparam int          PROG_MAX_US     = 3500;
  localparam int          FCLK_MHZ        = CLK_MHZ / TICK_DIV;
  localparam int          ERASE_TICKS     = ERASE_MAX_US * FCLK_MHZ;
  localparam int          PROG_TICKS      = PROG_MAX_US * FCLK_MHZ;
  localparam int          OVERHEAD_CYC    = 4;
  localparam int          TIME_W          = 20;
  typedef enum logic [1:0] {
    OP_NONE  = 2'h0,
    OP_PROG  = 2'h1,
    OP_ERASE = 2'h2
  } pe_op_t;
  typedef enum logic [1:0] {
    PE_IDLE  = 2'h0,
    PE_SETUP = 2'h1,
    PE_RUN   = 2'h2,
    PE_DONE  = 2'h3
  } pe_state_t;
endpackage

// ===== verilog/pe_timer.sv
module pe_timer
  import flash_access_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              start,
  input  wire logic [TIME_W-1:0] ticks,
  output logic                   busy,
  output logic                   done
);
  // Internal flash clock as a divided tick from mclk
  logic [4:0]        div;
  logic [TIME_W-1:0] left;
  wire               tick = (div == 5'(TICK_DIV - 1));

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      div  <= 5'h00;
      left <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      div  <= tick ? 5'h00 : div + 5'h01;
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        left <= ticks;
      end else if (busy && tick) begin
        if (left <= 20'h00001) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        left <= left - 20'h00001;
      end
    end
  end
endmodule

// ===== verilog/flash_access_timing_ctrl.sv
// What this block does
// [R1] Software sets wait count: 1 to 8MHz, 2 to 13, 3 to 17, else 4.
// [R2] Software sets extension at least 1 above 80 MHz system clock.
// [R3] Wait states only on non-sequential reads; sequential reads hidden. Code stalls a sequential read one cycle when the prefetch misses.
// [R4] Prefetch fetches following words ahead for sequential streams.
// [R5] Up to 7 modules busy if reads hit one module; else only 1.
// [R6] Module 6 may be erased or programmed while others are read.
// [R7] Erase finishes within 8.0 ms, page program within 3.5 ms.
// [R8] Durations timed from flash clock plus a few system clock cycles.
// [R9] Delivered erased with no protection active.
// [R10] Non-sequential read stalls wait count plus extension before data.
module flash_access_timing_ctrl
  import flash_access_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   rst_b,
  input  wire logic [WAIT_W-1:0]      flash_wait_count,
  input  wire logic [EXT_W-1:0]       wait_count_extension,
  input  wire logic                   rd_req,
  input  wire logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [NUM_MODULES-1:0] modules_being_read,
  input  wire logic [DATA_W-1:0]      array_data,
  input  wire logic                   pe_req,
  input  wire pe_op_t                 pe_op,
  input  wire logic [NUM_MODULES-1:0] pe_modules,
  output logic                        rd_ready,
  output logic [DATA_W-1:0]           rd_data,
  output logic [ADDR_W-1:0]           array_addr,
  output logic                        pe_accept,
  output logic                        pe_reject,
  output logic                        pe_busy,
  output logic                        pe_done,
  output logic [NUM_MODULES-1:0]      pe_active,
  output logic                        protect_on
);
  logic [ADDR_W-1:0] last_addr;
  logic              last_valid;
  logic [ADDR_W-1:0] pf_addr;
  logic              pf_valid;
  logic [DATA_W-1:0] pf_data;
  logic [3:0]        stall;
  logic              rd_busy;
  pe_state_t         state;
  logic [2:0]        ovh;
  logic              tmr_start;
  logic [TIME_W-1:0] tmr_ticks;
  logic              tmr_busy;
  logic              tmr_done;

  // Sequential means the next word after the previous read
  wire [ADDR_W-1:0] next_addr = last_addr + 24'h000004;
  wire seq_hit  = last_valid && (rd_addr == next_addr); // [R3]
  wire pf_hit   = pf_valid && (rd_addr == pf_addr); // [R4]
  wire [3:0] full_stall = {1'b0, flash_wait_count}
                        + {2'b00, wait_count_extension}; // [R10]
  wire [3:0] next_stall = pf_hit ? 4'h0 : (seq_hit ? 4'h1 : full_stall);

  // Count read modules once
  wire [NUM_MODULES-1:0] reads_ext = modules_being_read;
  logic [2:0] rd_count;
  logic [2:0] pe_count;
  always_comb begin
    rd_count = 3'h0;
    pe_count = 3'h0;
    for (int i = 0; i < NUM_MODULES; i++) begin
      rd_count = rd_count + {2'b00, reads_ext[i]};
      pe_count = pe_count + {2'b00, pe_modules[i]};
    end
  end
  wire overlap   = |(pe_modules & modules_being_read); // [R5]
  wire only_free = (pe_modules == (7'h01 << FREE_MODULE)); // [R6]
  wire [2:0] lim = (rd_count <= 3'h1) ? 3'(PAR_LIMIT_ONE)
                                      : 3'(PAR_LIMIT_MANY); // [R5]
  wire pe_ok = !overlap && (pe_count != 3'h0)
             && ((pe_count <= lim) || only_free); // [R5] [R6]
  wire pe_take = pe_req && (state == PE_IDLE) && (pe_op != OP_NONE);

  // Read path
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_busy    <= 1'b0;
      rd_ready   <= 1'b0;
      stall      <= 4'h0;
      rd_data    <= '0;
      array_addr <= '0;
      last_addr  <= '0;
      last_valid <= 1'b0;
      pf_valid   <= 1'b0;
      pf_addr    <= '0;
      pf_data    <= '0;
    end else begin
      rd_ready <= 1'b0;
      if (rd_req && !rd_busy && !rd_ready) begin
        rd_busy    <= 1'b1;
        stall      <= next_stall;
        array_addr <= rd_addr;
        last_addr  <= rd_addr;
        last_valid <= 1'b1;
      end else if (rd_busy && stall != 4'h0) begin
        stall <= stall - 4'h1; // [R10]
      end else if (rd_busy) begin
        rd_busy    <= 1'b0;
        rd_ready   <= 1'b1;
        rd_data    <= pf_hit ? pf_data : array_data;
        pf_valid   <= 1'b0;
        array_addr <= next_addr; // [R4]
      end else if (!pf_valid && last_valid) begin
        // Speculative fetch of the following word while idle
        pf_addr  <= next_addr; // [R4]
        pf_data  <= array_data;
        pf_valid <= (array_addr == next_addr);
      end
    end
  end

  // Program and erase sequencer
  assign tmr_start = (state == PE_SETUP) && (ovh == 3'h0);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state      <= PE_IDLE;
      ovh        <= 3'h0;
      tmr_ticks  <= '0;
      pe_accept  <= 1'b0;
      pe_reject  <= 1'b0;
      pe_busy    <= 1'b0;
      pe_done    <= 1'b0;
      pe_active  <= '0;
      protect_on <= 1'b0; // [R9]
    end else begin
      pe_accept <= 1'b0;
      pe_reject <= 1'b0;
      pe_done   <= 1'b0;
      unique case (state)
        PE_IDLE: begin
          if (pe_take && pe_ok) begin
            state     <= PE_SETUP;
            ovh       <= 3'(OVERHEAD_CYC - 1); // [R8]
            tmr_ticks <= (pe_op == OP_ERASE) ? 20'(ERASE_TICKS)
                                             : 20'(PROG_TICKS); // [R7]
            pe_accept <= 1'b1;
            pe_busy   <= 1'b1;
            pe_active <= pe_modules;
          end else if (pe_take) begin
            pe_reject <= 1'b1; // [R5]
          end
        end
        PE_SETUP: begin
          if (ovh == 3'h0) state <= PE_RUN;
          else ovh <= ovh - 3'h1; // [R8]
        end
        PE_RUN: begin
          if (tmr_done) state <= PE_DONE; // [R7]
        end
        PE_DONE: begin
          state     <= PE_IDLE;
          pe_busy   <= 1'b0;
          pe_done   <= 1'b1;
          pe_active <= '0;
        end
      endcase
    end
  end

  pe_timer u_timer (
    .mclk  (mclk),
    .rst_b (rst_b),
    .start (tmr_start),
    .ticks (tmr_ticks),
    .busy  (tmr_busy),
    .done  (tmr_done)
  );

  sequence acc_s;
    pe_accept ##1 pe_busy;
  endsequence
  property full_stall_p;
    @(posedge mclk) disable iff (!rst_b)
      (rd_req && !rd_busy && !rd_ready && !seq_hit && !pf_hit)
      |=> (stall == $past(full_stall));
  endproperty
  nonseq_stall_a: assert property (full_stall_p) // [R10]
    else $error("stall not wait plus extension");
  seq_short_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (rd_req && !rd_busy && !rd_ready && seq_hit) |=> stall <= 4'h1) // [R3]
    else $error("sequential read fully stalled");
  overlap_rej_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (pe_take && overlap) |=> pe_reject && !pe_accept) // [R5]
    else $error("read module accepted for erase");
  free_mod_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (pe_take && only_free && !overlap) |=> pe_accept) // [R6]
    else $error("module six refused");
  accept_busy_a: assert property (@(posedge mclk) disable iff (!rst_b)
    acc_s |-> ##[1:10] state == PE_RUN) // [R8]
    else $error("overhead not bounded");
  done_idle_a: assert property (@(posedge mclk) disable iff (!rst_b)
    pe_done |-> !pe_busy && pe_active == '0) // [R7]
    else $error("done while busy");
  timer_run_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (state == PE_RUN) |-> (tmr_busy || tmr_done)) // [R8]
    else $error("run state without timer");
  prefetch_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (rd_req && !rd_busy && !rd_ready && pf_hit) |=> ##1 rd_ready) // [R4]
    else $error("prefetch hit not fast");
  no_protect_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !protect_on) // [R9]
    else $error("protection active");
endmodule

// ===== tb/flash_array_model.sv
module flash_array_model
  import flash_access_pkg::*;
(
  input  wire logic [ADDR_W-1:0] array_addr,
  output logic      [DATA_W-1:0] array_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Word carries its own address so a stale fetch cannot pass
  assign array_data = {~array_addr[7:0], array_addr};
endmodule

// ===== tb/flash_access_timing_ctrl_test.sv
module flash_access_timing_ctrl_test
  import flash_access_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   mclk = 1'b0;
  logic                   rst_b = 1'b0;
  logic                   rd_req = 1'b0;
  logic                   pe_req = 1'b0;
  logic [WAIT_W-1:0]      flash_wait_count = 3'h4;
  logic [EXT_W-1:0]       wait_count_extension = 2'h1;
  logic [ADDR_W-1:0]      rd_addr = 24'h000000;
  logic [ADDR_W-1:0]      array_addr;
  logic [NUM_MODULES-1:0] modules_being_read = 7'h00;
  logic [NUM_MODULES-1:0] pe_modules = 7'h00;
  logic [NUM_MODULES-1:0] pe_active;
  logic [DATA_W-1:0]      array_data;
  logic [DATA_W-1:0]      rd_data;
  pe_op_t                 pe_op = OP_NONE;
  logic                   rd_ready;
  logic                   pe_accept;
  logic                   pe_reject;
  logic                   pe_busy;
  logic                   pe_done;
  logic                   protect_on;
  int                     n_fail = 0;
  int                     n_checks = 0;

  always #4 mclk = ~mclk;

  flash_access_timing_ctrl dut_u (.mclk, .rst_b, .flash_wait_count,
    .wait_count_extension, .rd_req, .rd_addr, .modules_being_read,
    .array_data, .pe_req, .pe_op, .pe_modules, .rd_ready, .rd_data,
    .array_addr, .pe_accept, .pe_reject, .pe_busy, .pe_done, .pe_active,
    .protect_on);
  flash_array_model far_u (.array_addr, .array_data);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [23:0] a, output int n);
    n = 0;
    @(posedge mclk);
    rd_req <= 1'b1;
    rd_addr <= a;
    @(posedge mclk);
    while (n < 20) begin
      @(posedge mclk);
      #1;
      n++;
      if (rd_ready === 1'b1) break;
    end
    chk(rd_data, {~a[7:0], a});
    @(posedge mclk);
    rd_req <= 1'b0;
  endtask

  task automatic do_reset(input int cyc);
    @(posedge mclk);
    rst_b <= 1'b0;
    repeat (cyc) @(posedge mclk);
    chk({pe_busy, rd_ready, pe_active}, 32'h0);
    chk(protect_on, 32'h0);
    rst_b <= 1'b1;
  endtask

  task automatic t_nonseq;
    int n;
    // Stay at or above legal minimums for 125 MHz
    for (int w = 4; w < 8; w++) begin
      for (int e = 1; e < 4; e++) begin
        @(posedge mclk);
        flash_wait_count <= w[2:0];
        wait_count_extension <= e[1:0];
        rd(24'h010000 * w + 24'h000100 * e, n);
        // Ready shows one edge after the stall has run out
        chk(n, 1 + w + e);
      end
    end
    $display("test nonseq done");
  endtask

  task automatic t_seq;
    int n;
    rd(24'h000400, n);
    rd(24'h000404, n);
    chk(n <= 3, 1);
    chk(n, 1);
    repeat (4) @(posedge mclk);
    rd(24'h000408, n);
    chk(n, 1);
    $display("test seq done");
  endtask

  task automatic pe(input pe_op_t op, input logic [6:0] rm, m,
                    input logic acc);
    int n;
    n = 0;
    @(posedge mclk);
    modules_being_read <= rm;
    pe_op <= op;
    pe_modules <= m;
    pe_req <= 1'b1;
    @(posedge mclk);
    pe_req <= 1'b0;
    #1;
    while (n < 4 && pe_accept !== 1'b1 && pe_reject !== 1'b1) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk({pe_accept, pe_reject}, {acc, ~acc});
    if (acc) begin
      chk(pe_active, m);
      // Far short of the timed span, so still running
      repeat (20) @(posedge mclk);
      #1;
      chk({pe_busy, pe_done}, 2'b10);
      do_reset(2);
    end
  endtask

  task automatic t_pe;
    pe(OP_ERASE, 7'h01, 7'h01, 1'b0);
    pe(OP_PROG, 7'h03, 7'h0C, 1'b0);
    pe(OP_PROG, 7'h03, 7'h04, 1'b1);
    pe(OP_ERASE, 7'h03, 7'h40, 1'b1);
    pe(OP_PROG, 7'h01, 7'h00, 1'b0);
    pe(OP_ERASE, 7'h01, 7'h7E, 1'b1);
    pe(OP_PROG, 7'h00, 7'h7F, 1'b1);
    $display("test pe done");
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    do_reset(12);
    t_nonseq;
    t_seq;
    t_pe;
    final_report;
  end

  initial begin
    #400000;
    n_fail++;
    final_report;
  end
endmodule
